// [rtl/flash_host_pkg.sv]
// Purpose: shared constants and types for the serial flash host controller
// Assumes: 20 MHz core clock, flash link clock made here by a divider
// Notes: register offsets are byte addresses on the Avalon slave
package flash_host_pkg;
	// Avalon address width
	localparam int AV_ADDR_W = 5;
	// Register byte offsets
	localparam logic [4:0] OFF_CMD = 5'h00;
	localparam logic [4:0] OFF_ADDR = 5'h04;
	localparam logic [4:0] OFF_COUNT = 5'h08;
	localparam logic [4:0] OFF_STATUS = 5'h0c;
	localparam logic [4:0] OFF_DATA = 5'h10;
	// Status field positions
	localparam int ST_BUSY = 0;
	localparam int ST_REFUSED = 1;
	localparam int ST_RX_VALID = 2;
	localparam int ST_TX_FULL = 3;
	// Reset values and limits
	localparam logic [8:0] COUNT_RESET = 9'h001;
	localparam logic [8:0] COUNT_MAX = 9'h100;
	localparam logic [3:0] IO_IDLE_OUT = 4'hc;
	localparam logic [3:0] IO_IDLE_OE_N = 4'h2;
	// Flash opcodes and fill bytes
	localparam logic [7:0] OPC_ID_SINGLE = 8'h90;
	localparam logic [7:0] OPC_ID_DUAL = 8'h92;
	localparam logic [7:0] OPC_ID_QUAD = 8'h94;
	localparam logic [7:0] OPC_UNIQUE = 8'h4b;
	localparam logic [7:0] OPC_JEDEC = 8'h9f;
	localparam logic [7:0] OPC_PARAM = 8'h5a;
	localparam logic [7:0] OPC_SEC_ERASE = 8'h44;
	localparam logic [7:0] OPC_SEC_PROG = 8'h42;
	localparam logic [7:0] MODE_CONTINUE = 8'hff;
	localparam logic [7:0] DUMMY_FILL = 8'h00;
	// Dummy byte counts
	localparam logic [8:0] UNIQUE_DUMMY_BYTES = 9'h004;
	localparam logic [8:0] PARAM_DUMMY_BYTES = 9'h001;
	// Security register selector range
	localparam logic [3:0] SEC_FIRST = 4'h1;
	localparam logic [3:0] SEC_LAST = 4'h3;
	// Timing in ns and derived cycle counts
	localparam int CORE_PERIOD_NS = 50;
	localparam int LINK_HALF_NS = 200;
	localparam int CS_HIGH_NS = 100;
	function automatic int cycles_min(input int ns);
		return (ns + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;
	endfunction
	localparam logic [2:0] HALF_CYCLES = 3'(cycles_min(LINK_HALF_NS));
	localparam logic [8:0] CS_HIGH_CYCLES = 9'(cycles_min(CS_HIGH_NS));
	// Commands that software may order
	typedef enum logic [2:0] {
		CMD_ID_SINGLE = 3'h0, CMD_ID_DUAL = 3'h1, CMD_ID_QUAD = 3'h2, CMD_UNIQUE = 3'h3,
		CMD_JEDEC = 3'h4, CMD_PARAM = 3'h5, CMD_SEC_ERASE = 3'h6, CMD_SEC_PROG = 3'h7
	} cmd_t;
	// Lanes used per link clock
	typedef enum logic [1:0] {LANE_SINGLE = 2'h0, LANE_DUAL = 2'h1, LANE_QUAD = 2'h2} lanes_t;
	// Command phases
	typedef enum logic [2:0] {
		PH_IDLE = 3'h0, PH_OPCODE = 3'h1, PH_ADDR = 3'h2, PH_MODE = 3'h3,
		PH_DUMMY = 3'h4, PH_XFER = 3'h5, PH_CS_HIGH = 3'h6
	} phase_t;
endpackage

// [rtl/link_if.sv]
// Purpose: byte handshake between the command sequencer and the link engine
// Assumes: both ends on core_clk
// Notes: start is taken only while busy is low
interface link_if;
	logic start;
	flash_host_pkg::lanes_t lanes;
	logic drive;
	logic [7:0] tx_byte;
	logic cs_active;
	logic busy;
	logic done;
	logic [7:0] rx_byte;
	// Sequencer end
	modport seq(output start, lanes, drive, tx_byte, cs_active, input busy, done, rx_byte);
	// Engine end
	modport eng(input start, lanes, drive, tx_byte, cs_active, output busy, done, rx_byte);
endinterface

// [rtl/spi_link.sv]
// Purpose: shifts one byte over 1, 2 or 4 flash lines per request
// Assumes: link clock idles low, device changes data after falling edges
// Notes: inputs pass two flip-flops; sampled at the rising edge
module spi_link (
	// Clock and reset
	input wire logic core_clk,
	input wire logic srst,
	// Sequencer side
	link_if.eng lk,
	// Flash pins
	output logic cs_n,
	output logic sclk,
	output logic [3:0] io_out,
	output logic [3:0] io_oe_n,
	input wire logic [3:0] io_in
);
	import flash_host_pkg::*;
	// Whole engine state
	typedef struct packed {
		logic [3:0] sync1;
		logic [3:0] sync2;
		logic busy;
		logic done;
		logic sclk;
		logic [2:0] div;
		logic [3:0] clks;
		lanes_t lanes;
		logic drive;
		logic [7:0] shift;
		logic [7:0] rx;
		logic cs_n;
		logic [3:0] io_out;
		logic [3:0] io_oe_n;
	} link_t;
	link_t s, next_s;
	// Output enables and levels for the top bits of a byte
	function automatic logic [7:0] pins_of(input logic [7:0] b, input lanes_t l, input logic d);
		if (l == LANE_QUAD) return {d ? 4'h0 : 4'hf, b[7:4]};
		if (l == LANE_DUAL) return {d ? 4'h0 : 4'h3, 2'h3, b[7:6]};
		return {IO_IDLE_OE_N, 3'h6, b[7]};
	endfunction
	// Bits moved per link clock
	function automatic logic [3:0] bits_of(input lanes_t l);
		return (l == LANE_QUAD) ? 4'h4 : (l == LANE_DUAL) ? 4'h2 : 4'h1;
	endfunction
	// Shift the sampled lines into the receive byte
	function automatic logic [7:0] sample(input logic [7:0] r, input logic [3:0] d, input lanes_t l);
		if (l == LANE_QUAD) return {r[3:0], d};
		if (l == LANE_DUAL) return {r[5:0], d[1:0]};
		return {r[6:0], d[1]};
	endfunction
	// Next state: synchroniser, divider and shifter
	always_comb begin
		next_s = s;
		next_s.sync1 = io_in;
		next_s.sync2 = s.sync1;
		next_s.done = 1'b0;
		next_s.cs_n = !lk.cs_active;
		if (!s.busy) begin
			// Load a byte and present its first bits
			if (lk.start) begin
				next_s.busy = 1'b1;
				next_s.div = 3'h0;
				next_s.clks = 4'(4'h8 / bits_of(lk.lanes));
				next_s.lanes = lk.lanes;
				next_s.drive = lk.drive;
				next_s.shift = lk.tx_byte;
				{next_s.io_oe_n, next_s.io_out} = pins_of(lk.tx_byte, lk.lanes, lk.drive);
			end
		end else if (s.div == HALF_CYCLES - 3'h1) begin
			next_s.div = 3'h0;
			next_s.sclk = !s.sclk;
			if (!s.sclk) begin
				// Rising edge: take device data
				next_s.rx = sample(s.rx, s.sync2, s.lanes); // [R3]
			end else if (s.clks == 4'h1) begin
				// Last falling edge ends the byte
				next_s.busy = 1'b0;
				next_s.done = 1'b1;
			end else begin
				// Falling edge: next bits out, MSB first
				next_s.clks = s.clks - 4'h1;
				next_s.shift = s.shift << bits_of(s.lanes);
				{next_s.io_oe_n, next_s.io_out} =
					pins_of(s.shift << bits_of(s.lanes), s.lanes, s.drive); // [R1]
			end
		end else begin
			next_s.div = s.div + 3'h1;
		end
	end
	// State register
	always_ff @(posedge core_clk) begin
		if (srst) begin
			s <= '0;
			s.cs_n <= 1'b1;
			s.io_out <= IO_IDLE_OUT;
			s.io_oe_n <= IO_IDLE_OE_N;
		end else begin
			s <= next_s;
		end
	end
	// Outputs
	assign cs_n = s.cs_n;
	assign sclk = s.sclk;
	assign io_out = s.io_out;
	assign io_oe_n = s.io_oe_n;
	assign lk.busy = s.busy;
	assign lk.done = s.done;
	assign lk.rx_byte = s.rx;
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (srst);
	a_sclk_high: assert property ($rose(sclk) |-> sclk [*4]) // [R1]
		else $error("link clock high phase too short");
	a_data_steady: assert property (sclk |-> $stable(io_out)) // [R1]
		else $error("data changed while link clock high");
	a_single_byte: assert property (lk.start && !s.busy && lk.lanes == LANE_SINGLE // [R1]
		|-> ##65 lk.done) else $error("single lane byte timing wrong");
	a_dual_byte: assert property (lk.start && !s.busy && lk.lanes == LANE_DUAL // [R3]
		|-> ##33 lk.done) else $error("dual lane byte timing wrong");
endmodule

// [rtl/flash_host.sv]
// Purpose: host controller issuing flash identification and security commands
// Assumes: device write enable set beforehand by software with other means
// Notes: software orders commands over Avalon-MM; data streams via DATA
// Functional notes
// [R1] 90h, zero address, single-lane alternating ID bytes
// [R2] 92h sends zero address two bits per clock
// [R3] Dual ID bytes return two bits per clock
// [R4] Send continuation byte FFh after multi-lane address
// [R5] 94h address and ID bytes four bits per clock
// [R6] 4Bh, four dummy bytes, then 64-bit ID
// [R7] 9Fh returns maker, memory type, capacity bytes
// [R8] 5Ah, address, eight dummy clocks, then data
// [R9] Parameter address upper sixteen bits must be zero
// [R10] Parameter read only on single lane
// [R11] Device drops security erase without write enable
// [R12] Security register chosen by address bits fifteen-twelve
// [R13] Release select right after last erase address bit
// [R14] Device busy during self-timed security erase
// [R15] Device clears write enable after security erase
// [R16] Locked security register ignores erase
// [R17] Locked security register ignores program
// [R18] 42h with address and one to 256 bytes
// [R19] Keep select low through whole program command
// [R20] Suspended device refuses matching security opcodes
// [R21] Erased security register reads all ones
module flash_host (
	// Clock and reset
	input wire logic core_clk,
	input wire logic srst,
	// Avalon-MM slave
	input wire logic [flash_host_pkg::AV_ADDR_W-1:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [31:0] writedata,
	output logic [31:0] readdata,
	output logic waitrequest,
	// Flash pins
	output logic cs_n,
	output logic sclk,
	output logic [3:0] io_out,
	output logic [3:0] io_oe_n,
	input wire logic [3:0] io_in
);
	import flash_host_pkg::*;

	// Whole controller state
	typedef struct packed {
		phase_t phase; // Command phase
		cmd_t cmd; // Command in progress
		logic [23:0] addr; // Flash address
		logic [8:0] count; // Data byte count
		logic [8:0] idx; // Byte or gap counter
		logic issued; // Byte handed to engine
		logic refused; // Last order rejected
		logic [7:0] rx_byte; // Byte for software
		logic rx_valid; // Received byte waiting
		logic [7:0] tx_hold; // Program byte from software
		logic tx_full; // Program byte waiting
		logic ack; // Bus answer cycle
		logic [31:0] readdata; // Registered read answer
	} host_t;
	host_t s, next_s;

	// Link handshake
	link_if lk();

	// Byte engine and pin driver
	spi_link u_link (
		.core_clk(core_clk),
		.srst(srst),
		.lk(lk),
		.cs_n(cs_n),
		.sclk(sclk),
		.io_out(io_out),
		.io_oe_n(io_oe_n),
		.io_in(io_in)
	);

	// Opcode for a command
	function automatic logic [7:0] opcode_of(input cmd_t c);
		case (c)
			CMD_ID_SINGLE: return OPC_ID_SINGLE;
			CMD_ID_DUAL: return OPC_ID_DUAL;
			CMD_ID_QUAD: return OPC_ID_QUAD;
			CMD_UNIQUE: return OPC_UNIQUE;
			CMD_JEDEC: return OPC_JEDEC;
			CMD_PARAM: return OPC_PARAM;
			CMD_SEC_ERASE: return OPC_SEC_ERASE;
			default: return OPC_SEC_PROG;
		endcase
	endfunction

	// Commands that take bytes from the device
	function automatic logic is_read(input cmd_t c);
		return (c != CMD_SEC_ERASE) && (c != CMD_SEC_PROG);
	endfunction

	// Manufacturer/device ID reads send a zero address
	function automatic logic is_id(input cmd_t c);
		return (c == CMD_ID_SINGLE) || (c == CMD_ID_DUAL) || (c == CMD_ID_QUAD);
	endfunction

	// Lanes for a phase of a command
	function automatic lanes_t lanes_of(input cmd_t c, input phase_t p);
		if (p == PH_OPCODE || p == PH_DUMMY) return LANE_SINGLE;
		if (c == CMD_ID_DUAL) return LANE_DUAL;
		if (c == CMD_ID_QUAD) return LANE_QUAD;
		return LANE_SINGLE;
	endfunction

	// Security register address is well formed
	function automatic logic sec_ok(input logic [23:0] a);
		return (a[23:16] == 8'h00) && (a[11:8] == 4'h0) &&
			(a[15:12] >= SEC_FIRST) && (a[15:12] <= SEC_LAST);
	endfunction

	// Whether an order may be sent to the device
	function automatic logic order_ok(input cmd_t c, input logic [23:0] a, input logic [8:0] n);
		logic len_ok;
		len_ok = (n != 9'h000) && (n <= COUNT_MAX);
		if (c == CMD_SEC_ERASE) return sec_ok(a);
		if (c == CMD_SEC_PROG) return sec_ok(a) && len_ok;
		if (c == CMD_PARAM) return (a[23:8] == 16'h0000) && len_ok;
		return len_ok;
	endfunction

	// Every access waits one cycle; a DATA access waits until it can be served
	assign waitrequest = (read || write) && !s.ack;
	assign readdata = s.readdata;

	// Bus access and command sequencing
	always_comb begin
		logic rx_wait;
		logic tx_wait;
		next_s = s;
		rx_wait = !s.rx_valid && (s.phase != PH_IDLE) && is_read(s.cmd);
		tx_wait = s.tx_full;
		next_s.ack = 1'b0;
		// First cycle of an access: build the answer
		if ((read || write) && !s.ack) begin
			if (address == OFF_DATA && read) begin
				next_s.ack = !rx_wait;
			end else if (address == OFF_DATA) begin
				next_s.ack = !tx_wait;
			end else begin
				next_s.ack = 1'b1;
			end
			// Read value, unmapped reads as zero
			if (address == OFF_CMD) begin
				next_s.readdata = {26'h0, s.phase, s.cmd};
			end else if (address == OFF_ADDR) begin
				next_s.readdata = {8'h00, s.addr};
			end else if (address == OFF_COUNT) begin
				next_s.readdata = {23'h0, s.count};
			end else if (address == OFF_STATUS) begin
				next_s.readdata = 32'h0;
				next_s.readdata[ST_BUSY] = s.phase != PH_IDLE;
				next_s.readdata[ST_REFUSED] = s.refused;
				next_s.readdata[ST_RX_VALID] = s.rx_valid;
				next_s.readdata[ST_TX_FULL] = s.tx_full;
			end else if (address == OFF_DATA) begin
				next_s.readdata = {24'h0, s.rx_byte};
			end else begin
				next_s.readdata = 32'h0;
			end
		end
		// Answer cycle: writes take effect
		if (s.ack && write) begin
			if (address == OFF_CMD && s.phase == PH_IDLE) begin
				next_s.cmd = cmd_t'(writedata[2:0]);
				if (order_ok(cmd_t'(writedata[2:0]), s.addr, s.count)) begin // [R9] [R12] [R18]
					next_s.phase = PH_OPCODE;
					next_s.refused = 1'b0;
					next_s.idx = 9'h000;
					next_s.issued = 1'b0;
					next_s.rx_valid = 1'b0;
					next_s.tx_full = 1'b0;
					if (is_id(cmd_t'(writedata[2:0]))) begin
						next_s.addr = 24'h000000; // [R1]
					end
				end else begin
					next_s.refused = 1'b1;
				end
			end else if (address == OFF_ADDR && s.phase == PH_IDLE) begin
				next_s.addr = writedata[23:0];
			end else if (address == OFF_COUNT && s.phase == PH_IDLE) begin
				next_s.count = writedata[8:0];
			end else if (address == OFF_DATA && s.cmd == CMD_SEC_PROG && s.phase != PH_IDLE) begin
				next_s.tx_hold = writedata[7:0];
				next_s.tx_full = 1'b1;
			end
		end
		// Answer cycle: a DATA read consumes the byte
		if (s.ack && read && address == OFF_DATA) begin
			next_s.rx_valid = 1'b0;
		end
		// Byte handed to the engine
		if (lk.start) begin
			next_s.issued = 1'b1;
			if (s.phase == PH_XFER && !is_read(s.cmd)) begin
				next_s.tx_full = 1'b0;
			end
		end
		// Byte finished: advance the phase
		if (lk.done) begin
			next_s.issued = 1'b0;
			case (s.phase)
				PH_OPCODE: begin
					next_s.idx = 9'h000;
					if (s.cmd == CMD_JEDEC) begin
						next_s.phase = PH_XFER; // [R7]
					end else if (s.cmd == CMD_UNIQUE) begin
						next_s.phase = PH_DUMMY; // [R6]
					end else begin
						next_s.phase = PH_ADDR;
					end
				end
				PH_ADDR: begin
					if (s.idx == 9'h002) begin
						next_s.idx = 9'h000;
						if (s.cmd == CMD_ID_DUAL || s.cmd == CMD_ID_QUAD) begin
							next_s.phase = PH_MODE; // [R4]
						end else if (s.cmd == CMD_PARAM) begin
							next_s.phase = PH_DUMMY; // [R8]
						end else if (s.cmd == CMD_SEC_ERASE) begin
							next_s.phase = PH_CS_HIGH; // [R13]
						end else begin
							next_s.phase = PH_XFER;
						end
					end else begin
						next_s.idx = s.idx + 9'h001;
					end
				end
				PH_MODE: begin
					next_s.phase = PH_XFER;
				end
				PH_DUMMY: begin
					// Four bytes for the unique ID, one for parameters
					if (s.idx == (s.cmd == CMD_UNIQUE ? UNIQUE_DUMMY_BYTES : PARAM_DUMMY_BYTES)
						- 9'h001) begin
						next_s.idx = 9'h000;
						next_s.phase = PH_XFER; // [R6] [R8]
					end else begin
						next_s.idx = s.idx + 9'h001;
					end
				end
				PH_XFER: begin
					// Received bytes set the flag after any clear
					if (is_read(s.cmd)) begin
						next_s.rx_byte = lk.rx_byte;
						next_s.rx_valid = 1'b1;
					end
					if (s.idx == s.count - 9'h001) begin
						next_s.idx = 9'h000;
						next_s.phase = PH_CS_HIGH; // [R19]
					end else begin
						next_s.idx = s.idx + 9'h001;
					end
				end
				default: begin
					next_s.phase = s.phase;
				end
			endcase
		end
		// Select high gap before the next command
		if (s.phase == PH_CS_HIGH) begin
			if (s.idx == CS_HIGH_CYCLES - 9'h001) begin
				next_s.idx = 9'h000;
				next_s.phase = PH_IDLE;
			end else begin
				next_s.idx = s.idx + 9'h001;
			end
		end
	end

	// Byte request to the engine
	always_comb begin
		lk.start = 1'b0;
		lk.tx_byte = DUMMY_FILL;
		lk.drive = 1'b0;
		lk.lanes = lanes_of(s.cmd, s.phase); // [R2] [R5] [R10]
		lk.cs_active = (s.phase != PH_IDLE) && (s.phase != PH_CS_HIGH); // [R19]
		case (s.phase)
			PH_OPCODE: begin
				lk.start = !s.issued && !lk.busy;
				lk.tx_byte = opcode_of(s.cmd);
				lk.drive = 1'b1;
			end
			PH_ADDR: begin
				// Address MSB byte first
				lk.start = !s.issued && !lk.busy;
				if (s.idx == 9'h000) begin
					lk.tx_byte = s.addr[23:16];
				end else if (s.idx == 9'h001) begin
					lk.tx_byte = s.addr[15:8];
				end else begin
					lk.tx_byte = s.addr[7:0];
				end
				lk.drive = 1'b1;
			end
			PH_MODE: begin
				lk.start = !s.issued && !lk.busy;
				lk.tx_byte = MODE_CONTINUE; // [R4]
				lk.drive = 1'b1;
			end
			PH_DUMMY: begin
				// Dummy clocks on one lane: io[0] still driven with DUMMY_FILL, only io[1] released
				lk.start = !s.issued && !lk.busy;
			end
			PH_XFER: begin
				// Reads wait for software, programs for a byte
				if (is_read(s.cmd)) begin
					lk.start = !s.issued && !lk.busy && !s.rx_valid;
				end else begin
					lk.start = !s.issued && !lk.busy && s.tx_full; // [R18]
					lk.tx_byte = s.tx_hold;
					lk.drive = 1'b1;
				end
			end
			default: begin
				lk.start = 1'b0;
			end
		endcase
	end

	// State register
	always_ff @(posedge core_clk) begin
		if (srst) begin
			s <= '0;
			s.count <= COUNT_RESET;
		end else begin
			s <= next_s;
		end
	end

	// Checks on the command stream
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (srst);

	// Last address byte of an erase ends
	sequence erase_last_addr;
		s.phase == PH_ADDR && s.cmd == CMD_SEC_ERASE && s.idx == 9'h002 && lk.done;
	endsequence
	// Select released on the following edges
	sequence select_drops;
		(s.phase == PH_CS_HIGH && !lk.cs_active) ##1 cs_n;
	endsequence

	a_opcode_first: assert property (lk.start && s.phase == PH_OPCODE // [R1]
		|-> lk.lanes == LANE_SINGLE && lk.tx_byte == opcode_of(s.cmd))
		else $error("opcode not sent single lane");
	a_id_zero_addr: assert property (lk.start && s.phase == PH_ADDR && is_id(s.cmd) // [R1]
		|-> lk.tx_byte == 8'h00) else $error("ID read address not zero");
	a_dual_addr: assert property (lk.start && s.cmd == CMD_ID_DUAL && s.phase != PH_OPCODE // [R2]
		|-> lk.lanes == LANE_DUAL) else $error("dual ID not on two lanes");
	a_mode_ones: assert property (lk.start && s.phase == PH_MODE // [R4]
		|-> lk.tx_byte == MODE_CONTINUE && lk.drive && lk.lanes != LANE_SINGLE)
		else $error("continuation byte wrong");
	a_quad_lanes: assert property (lk.start && s.cmd == CMD_ID_QUAD && s.phase != PH_OPCODE // [R5]
		|-> lk.lanes == LANE_QUAD) else $error("quad ID not on four lanes");
	a_unique_dummy: assert property ($rose(s.phase == PH_XFER) && s.cmd == CMD_UNIQUE // [R6]
		|-> $past(s.idx) == 9'h003 && $past(s.phase) == PH_DUMMY)
		else $error("unique ID dummy count wrong");
	a_param_single: assert property (lk.start && s.cmd == CMD_PARAM // [R10]
		|-> lk.lanes == LANE_SINGLE) else $error("parameter read not single lane");
	a_param_addr: assert property (s.phase != PH_IDLE && s.cmd == CMD_PARAM // [R9]
		|-> s.addr[23:8] == 16'h0000) else $error("parameter address high bits set");
	a_sec_select: assert property (s.phase != PH_IDLE && !is_read(s.cmd) // [R12]
		|-> sec_ok(s.addr)) else $error("security register address invalid");
	a_erase_cs_end: assert property (erase_last_addr |=> select_drops) // [R13]
		else $error("select not released after erase address");
	a_prog_length: assert property ($rose(s.phase == PH_OPCODE) && s.cmd == CMD_SEC_PROG // [R18]
		|-> s.count != 9'h000 && s.count <= COUNT_MAX) else $error("program length out of range");
	a_prog_cs_held: assert property (s.phase == PH_XFER && s.cmd == CMD_SEC_PROG && lk.busy // [R19]
		|-> !cs_n) else $error("select high during program data");
endmodule

// [sim/flash_dev_model.sv]
// Purpose: behavioural serial flash facing the host controller
// Assumes: link clock idles low; host drives only lanes it enables
// Notes: proto_err counts wire faults made by the host
module flash_dev_model #(
	parameter logic [7:0] MAN_ID = 8'h5c, // Arbitrary maker code
	parameter logic [7:0] DEV_ID = 8'h11, // Arbitrary device code
	parameter logic [7:0] MEMORY_TYPE_BYTE = 8'h60,
	parameter logic [7:0] CAPACITY_BYTE = 8'h12,
	parameter logic [63:0] UID = 64'h0123_4567_89ab_cdef,
	parameter int ERASE_NS = 3000
) (
	// Flash pins
	input wire logic cs_n,
	input wire logic sclk,
	input wire logic [3:0] io,
	output logic [3:0] dev_out,
	output logic [3:0] dev_oe_n
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] opc, mode, sec [3][256];
	logic [23:0] adr;
	logic [2:0] lock = 3'h4; // Register three locked
	logic write_enable_latch = 1'b0, busy = 1'b0, susp_e = 1'b0, susp_p = 1'b0;
	logic [1:0] er;
	logic [7:0] q [$];
	logic [3:0] v, m;
	int n, w, k, st, proto_err = 0;
	initial begin
		dev_oe_n = 4'hf;
		dev_out = 4'h0;
		foreach (sec[i, j]) sec[i][j] = 8'h0f; // Neither all ones nor all zeros
	end
	// Lane width and first output clock per opcode
	assign w = opc == 8'h92 ? 2 : opc == 8'h94 ? 4 : 1;
	assign m = 4'((1 << w) - 1);
	assign st = opc == 8'h90 ? 32 : opc == 8'h92 ? 24 : opc == 8'h94 ? 16 :
		opc == 8'h9f ? 8 : (opc == 8'h4b || opc == 8'h5a) ? 40 : 0;
	function automatic logic [7:0] byte_at(input int j);
		case (opc)
			8'h90, 8'h92, 8'h94: return j % 2 ? DEV_ID : MAN_ID;
			8'h9f: return j == 0 ? MAN_ID : j == 1 ? MEMORY_TYPE_BYTE : CAPACITY_BYTE;
			8'h4b: return UID[63 - 8 * (j % 8) -: 8];
			default: return 8'(adr[7:0] + j) ^ 8'ha5;
		endcase
	endfunction
	// Frame start
	always @(negedge cs_n) begin
		n = 0;
		opc = 8'h00;
		adr = 24'h0;
		mode = 8'h00;
	end
	// Shift in on rising link clock
	always @(posedge sclk) if (!cs_n) begin
		if (n < 8) opc = {opc[6:0], io[0]};
		else if (n < 8 + 24 / w) adr = (adr << w) | 24'(io & m);
		else if (w > 1 && n < 8 + 32 / w) mode = (mode << w) | 8'(io & m);
		else if (opc == 8'h42 && (n - 32) % 8 == 7) q.push_back({mode[6:0], io[0]});
		if (opc == 8'h42 && n >= 32) mode = {mode[6:0], io[0]};
		n++;
	end
	// Drive out after falling link clock
	always @(negedge sclk) if (!cs_n && st > 0 && n >= st) begin
		k = (n - st) * w;
		v = 4'(byte_at(k / 8) >> (8 - k % 8 - w)) & m;
		dev_oe_n = w == 1 ? 4'hd : ~m;
		dev_out = w == 1 ? {v[2:0], 1'b0} : v;
	end
	// Frame end: wire checks and commits
	always @(posedge cs_n) begin
		dev_oe_n = 4'hf;
		er = 2'(adr[15:12] - 4'h1);
		if (opc inside {8'h90, 8'h92, 8'h94} && adr != 24'h0) proto_err++;
		if (opc inside {8'h92, 8'h94} && mode != 8'hff) proto_err++;
		if (opc == 8'h5a && adr[23:8] != 16'h0) proto_err++;
		if (opc == 8'h42 && (n < 40 || n % 8 != 0)) proto_err++;
		if (adr[23:16] == 8'h0 && adr[11:8] == 4'h0 && adr[15:12] inside {[1:3]}
			&& !lock[er]) begin
			if (opc == 8'h44 && n == 32 && write_enable_latch && !susp_e) busy = 1'b1;
			if (opc == 8'h42 && write_enable_latch && !susp_p) begin
				foreach (q[i]) sec[er][8'(adr[7:0] + i)] &= q[i];
				write_enable_latch = 1'b0;
			end
		end
		q.delete();
	end
	// Self-timed erase
	always @(posedge busy) begin
		#(ERASE_NS);
		for (int i = 0; i < 256; i++) sec[er][i] = 8'hff;
		write_enable_latch = 1'b0;
		busy = 1'b0;
	end
endmodule

// [sim/tb_flash_host.sv]
// Purpose: self-checking bench for the flash host controller
// Assumes: device model stands on the flash pins
// Notes: Avalon master waits on waitrequest under a bound
module tb_flash_host;
	timeunit 1ns;
	timeprecision 1ns;
	import flash_host_pkg::*;
	`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin fail_count++; \
		$display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
	localparam logic [7:0] MAN = 8'h5c, DEVB = 8'h11, MEMT = 8'h60, CAPB = 8'h12; // Arbitrary
	localparam logic [63:0] UIDV = 64'h0123_4567_89ab_cdef;
	logic core_clk = 1'b0, srst = 1'b1, read = 1'b0, write = 1'b0;
	logic [4:0] address = 5'h00;
	logic [31:0] writedata = 32'h0, readdata, stat;
	logic waitrequest, cs_n, sclk;
	logic [3:0] io_out, io_oe_n, dev_out, dev_oe_n, io_w, noise = 4'h5;
	int fail_count = 0, num_checks = 0;
	// Wire level: host, then device, else changing pattern
	assign io_w = (io_out & ~io_oe_n) | (dev_out & ~dev_oe_n & io_oe_n) | (noise & io_oe_n & dev_oe_n);
	initial forever #25 core_clk = ~core_clk;
	always @(posedge core_clk) noise <= ~noise;
	flash_host DUT (.core_clk(core_clk), .srst(srst), .address(address), .read(read),
		.write(write), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
		.cs_n(cs_n), .sclk(sclk), .io_out(io_out), .io_oe_n(io_oe_n), .io_in(io_w));
	flash_dev_model #(.MAN_ID(MAN), .DEV_ID(DEVB), .MEMORY_TYPE_BYTE(MEMT), .CAPACITY_BYTE(CAPB),
		.UID(UIDV), .ERASE_NS(3000)) dev (.cs_n(cs_n), .sclk(sclk), .io(io_w),
		.dev_out(dev_out), .dev_oe_n(dev_oe_n));
	task automatic wrap_up();
		$display("checks=%0d fails=%0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask
	// One Avalon access, held until waitrequest low
	task automatic av(input logic wr, input logic [4:0] a, input logic [31:0] d,
		output logic [31:0] q);
		int i;
		@(posedge core_clk);
		address <= a;
		writedata <= d;
		write <= wr;
		read <= !wr;
		i = 0;
		do begin
			@(posedge core_clk);
			i++;
		end while (waitrequest !== 1'b0 && i < 4000);
		q = readdata;
		write <= 1'b0;
		read <= 1'b0;
		if (i >= 4000) begin
			fail_count++;
			wrap_up();
		end
	endtask
	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		logic [31:0] q;
		av(1'b1, a, d, q);
	endtask
	task automatic rd(input logic [4:0] a, input logic [31:0] e);
		logic [31:0] q;
		av(1'b0, a, 32'h0, q);
		`CHK(a == OFF_DATA ? {24'h0, q[7:0]} : q, e)
	endtask
	task automatic go(input logic [2:0] c, input logic [23:0] a, input logic [8:0] cnt);
		wr(OFF_ADDR, {8'h00, a});
		wr(OFF_COUNT, {23'h0, cnt});
		wr(OFF_CMD, {29'h0, c});
	endtask
	// Poll status until the command ends
	task automatic idle();
		int i;
		for (i = 0; i < 400; i++) begin
			av(1'b0, OFF_STATUS, 32'h0, stat);
			if (stat[ST_BUSY] === 1'b0) break;
		end
		if (i >= 400) begin
			fail_count++;
			wrap_up();
		end
	endtask
	task automatic t_regs();
		rd(OFF_COUNT, {23'h0, COUNT_RESET});
		rd(5'h14, 32'h0);
		wr(OFF_ADDR, 32'h0000_2a5c);
		rd(OFF_ADDR, 32'h0000_2a5c);
	endtask
	task automatic t_ids();
		cmd_t c [3] = '{CMD_ID_SINGLE, CMD_ID_DUAL, CMD_ID_QUAD};
		logic [7:0] jb [3] = '{MAN, MEMT, CAPB};
		foreach (c[i]) begin
			go(c[i], 24'h0, 9'h004);
			for (int j = 0; j < 4; j++) rd(OFF_DATA, j % 2 ? DEVB : MAN);
			idle();
		end
		go(CMD_JEDEC, 24'h0, 9'h003);
		foreach (jb[i]) rd(OFF_DATA, jb[i]);
		idle();
		go(CMD_UNIQUE, 24'h0, 9'h008);
		for (int i = 0; i < 8; i++) rd(OFF_DATA, UIDV[63 - 8 * i -: 8]);
		idle();
	endtask
	task automatic t_param();
		go(CMD_PARAM, 24'h0000fe, 9'h003);
		for (int i = 0; i < 3; i++) rd(OFF_DATA, 8'(8'hfe + i) ^ 8'ha5);
		idle();
		go(CMD_PARAM, 24'h000100, 9'h001);
		idle();
		`CHK(stat[ST_REFUSED], 1'b1)
	endtask
	task automatic t_erase();
		dev.write_enable_latch = 1'b1;
		go(CMD_SEC_ERASE, 24'h0020a7, 9'h001);
		idle();
		repeat (100) @(posedge core_clk);
		`CHK(dev.sec[1][8'h00], 8'hff)
		`CHK(dev.sec[1][8'hff], 8'hff)
		`CHK(dev.write_enable_latch, 1'b0)
		dev.write_enable_latch = 1'b1;
		go(CMD_SEC_ERASE, 24'h003000, 9'h001);
		idle();
		repeat (100) @(posedge core_clk);
		`CHK(dev.sec[2][8'h10], 8'h0f)
		go(CMD_SEC_ERASE, 24'h004000, 9'h001);
		idle();
		`CHK(stat[ST_REFUSED], 1'b1)
	endtask
	task automatic t_prog();
		dev.write_enable_latch = 1'b1;
		go(CMD_SEC_PROG, 24'h0020fe, 9'h002);
		wr(OFF_DATA, 32'h0000_003c);
		wr(OFF_DATA, 32'h0000_005a);
		idle();
		`CHK(dev.sec[1][8'hfe], 8'h3c)
		`CHK(dev.sec[1][8'hff], 8'h5a)
	endtask
	// Erase without write enable, erase while suspended, program to locked register
	task automatic t_guarded();
		go(CMD_SEC_ERASE, 24'h002000, 9'h001);
		idle();
		dev.write_enable_latch = 1'b1;
		dev.susp_e = 1'b1;
		go(CMD_SEC_ERASE, 24'h002000, 9'h001);
		idle();
		repeat (100) @(posedge core_clk);
		`CHK(dev.sec[1][8'hfe], 8'h3c)
		dev.susp_e = 1'b0;
		go(CMD_SEC_PROG, 24'h003000, 9'h001);
		wr(OFF_DATA, 32'h0000_0030);
		idle();
		`CHK(dev.sec[2][8'h00], 8'h0f)
	endtask
	// Main sequence
	initial begin
		repeat (5) @(posedge core_clk);
		srst <= 1'b0;
		t_regs();
		t_ids();
		t_param();
		t_erase();
		t_prog();
		t_guarded();
		`CHK(dev.proto_err, 0)
		wrap_up();
	end
endmodule
